/* common/asi_pkg.sv */
// Types shared by the audio event status block.
// Assumes nothing beyond the register header.
package asi_pkg;
  typedef enum logic [0:0] {
    ASI_IDLE = 1'b0,
    ASI_ACK  = 1'b1
  } asi_bus_state_t;
  typedef logic [7:0] asi_byte_t;
endpackage : asi_pkg

/* common/asi_regs.svh */
// Register indices, field positions and reset values of the audio event status block.
// Assumes byte address = 4 * index on a 32-bit Avalon-MM bus.
`ifndef ASI_REGS_SVH
`define ASI_REGS_SVH
`define ASI_IDX_STATUS   6'h07
`define ASI_IDX_MASK     6'h09
`define ASI_IDX_CTRL     6'h0a
`define ASI_IDX_IRQ_STAT 6'h0b
`define ASI_IDX_IRQ_CLR  6'h0c
`define ASI_IDX_IRQ_EN   6'h0d
`define ASI_STATUS_RST   8'h00
`define ASI_MASK_RST     8'h00
`define ASI_CTRL_RST     8'h00
`define ASI_IRQ_RST      8'h00
`define ASI_B_TX_SLIP    7
`define ASI_B_OUT_SLIP   6
`define ASI_B_RATE       5
`define ASI_B_OVR_LEFT   4
`define ASI_B_OVR_RIGHT  3
`define ASI_B_D_TO_E     2
`define ASI_B_E_TO_F     1
`define ASI_B_RX_ERR     0
`define ASI_C_LEVEL      0
`define ASI_C_BYPASS     1
`define ASI_C_OUTPUT_MASTER_CLOCK_ASYNC 2
`define ASI_C_BLK_IN     3
`define ASI_C_OUT_SLAVE  4
`define ASI_C_FRM_ASYNC  5
`define ASI_C_RATIO_LO   6
`define ASI_C_RATIO_HI   7
`define ASI_RATE_LIMIT   3
`endif

/* dv/asi_host_model.sv */
// Host model: an Avalon-MM master that issues one read or write at a time.
// Assumes a slave that lowers waitrequest within the bound of the transfer loop.
`timescale 1ns/1ps
module asi_host_model (
  // Clock
  input  wire logic        clk_sys_in,
  // Avalon-MM master
  output logic [7:0]       address_out,
  output logic             read_out,
  output logic             write_out,
  output logic [31:0]      writedata_out,
  input  wire logic [31:0] readdata_in,
  input  wire logic        waitrequest_in
);
  initial begin
    address_out = 8'h00;
    read_out = 1'b0;
    write_out = 1'b0;
    writedata_out = 32'h0;
  end

  // Released write data shows the inverse so a slave that samples late is caught.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdata, output logic ok);
    ok = 1'b0;
    rdata = 32'h0;
    @(posedge clk_sys_in);
    address_out <= a;
    read_out <= ~wr;
    write_out <= wr;
    writedata_out <= wd;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge clk_sys_in);
      if (waitrequest_in === 1'b0) begin
        ok = 1'b1;
        rdata = readdata_in;
        read_out <= 1'b0;
        write_out <= 1'b0;
        writedata_out <= ~wd;
      end
    end
  endtask : xfer
endmodule : asi_host_model

/* dv/asi_top_tb.sv */
// Self-checking bench for the audio event status block.
// Assumes the host model above and the register header of the block.
`timescale 1ns/1ps
`include "asi_regs.svh"
module asi_top_tb;
  localparam logic [7:0] A_ST = {`ASI_IDX_STATUS, 2'b00};
  localparam logic [7:0] A_MK = {`ASI_IDX_MASK, 2'b00};
  localparam logic [7:0] A_CT = {`ASI_IDX_CTRL, 2'b00};
  localparam logic [7:0] A_IS = {`ASI_IDX_IRQ_STAT, 2'b00};
  localparam logic [7:0] A_IC = {`ASI_IDX_IRQ_CLR, 2'b00};
  localparam logic [7:0] A_IE = {`ASI_IDX_IRQ_EN, 2'b00};
  logic               clk_sys = 1'b0;
  logic               rst_b = 1'b0;
  logic [7:0]         address;
  logic               rd_en, wr_en, wait_rq, irq;
  logic [31:0]        wdata, rdata;
  logic               tx_slip = 1'b0, blk = 1'b0, out_slip = 1'b0;
  logic [1:0]         ratio = 2'b00;
  logic               rate_valid = 1'b0, sample_valid = 1'b0;
  logic [15:0]        in_p = 16'h0001, out_p = 16'h0001;
  logic signed [25:0] left_acc = 26'sh0, right_acc = 26'sh0;
  logic [23:0]        left_s, right_s;
  logic               dte = 1'b0, eft = 1'b0, rxe = 1'b0;
  int                 err_count = 0;
  int                 check_count = 0;

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  asi_host_model asi_host_model_inst (.clk_sys_in(clk_sys), .address_out(address), .read_out(rd_en),
    .write_out(wr_en), .writedata_out(wdata), .readdata_in(rdata), .waitrequest_in(wait_rq));

  asi_top asi_top_inst (.clk_sys_in(clk_sys), .rst_b_in(rst_b), .address_in(address), .read_in(rd_en),
    .write_in(wr_en), .writedata_in(wdata), .readdata_out(rdata), .waitrequest_out(wait_rq),
    .irq_out(irq), .tx_sample_slip_in(tx_slip), .transmit_block_start_in(blk),
    .out_sample_slip_in(out_slip), .out_clock_ratio_in(ratio), .rate_valid_in(rate_valid),
    .in_period_in(in_p), .out_period_in(out_p), .sample_valid_in(sample_valid),
    .left_acc_in(left_acc), .right_acc_in(right_acc), .left_sample_out(left_s),
    .right_sample_out(right_s), .d_to_e_active_in(dte), .e_to_f_active_in(eft), .rx_error_in(rxe));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg

  task automatic chk_pin(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask : chk_pin

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [31:0] d;
    logic        ok;
    asi_host_model_inst.xfer(1'b0, a, 32'h0, d, ok);
    if (!ok) begin
      err_count++;
      end_of_test();
    end
    chk_reg(n, {24'h0, e}, d);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] d;
    logic        ok;
    asi_host_model_inst.xfer(1'b1, a, {24'h0, v}, d, ok);
    if (!ok) begin
      err_count++;
      end_of_test();
    end
  endtask : wr

  task automatic fire(input int k);
    @(posedge clk_sys);
    case (k)
      0: tx_slip <= 1'b1;
      1: out_slip <= 1'b1;
      2: dte <= 1'b1;
      3: eft <= 1'b1;
      default: rxe <= 1'b1;
    endcase
    @(posedge clk_sys);
    {tx_slip, out_slip, dte, eft, rxe} <= 5'h00;
  endtask : fire

  task automatic rate(input logic [15:0] o, input logic [7:0] e);
    @(posedge clk_sys);
    rate_valid <= 1'b1;
    in_p <= 16'h000a;
    out_p <= o;
    @(posedge clk_sys);
    rate_valid <= 1'b0;
    rd(A_ST, e, "status rate");
  endtask : rate

  task automatic tend(input string n);
    $display("test %s done", n);
  endtask : tend

  logic [7:0] ctl_tab [5] = '{8'h06, 8'h30, 8'h00, 8'h00, 8'h00};
  logic [7:0] exp_tab [5] = '{8'h80, 8'h40, 8'h04, 8'h02, 8'h01};

  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(A_ST, `ASI_STATUS_RST, "status reset");
    rd(A_MK, `ASI_MASK_RST, "mask reset");
    rd(A_CT, `ASI_CTRL_RST, "ctrl reset");
    rd(A_IE, `ASI_IRQ_RST, "irq_en reset");
    rd(8'h3c, 8'h00, "unmapped");
    tend("reset");
    fire(4);
    rd(A_ST, 8'h00, "status masked");
    wr(A_MK, 8'hff);
    rd(A_MK, 8'hff, "mask readback");
    tend("mask");
    // Each of five sources alone: its own bit after the event, cleared by the read.
    for (int k = 0; k < 5; k++) begin
      wr(A_CT, ctl_tab[k]);
      fire(k);
      rd(A_ST, exp_tab[k], "status event");
      rd(A_ST, 8'h00, "status cleared");
    end
    tend("events");
    wr(A_CT, 8'h01);
    @(posedge clk_sys);
    {dte, rxe} <= 2'b11;
    rd(A_ST, 8'h05, "level first");
    rd(A_ST, 8'h05, "level held");
    @(posedge clk_sys);
    {dte, rxe} <= 2'b00;
    rd(A_ST, 8'h05, "level last");
    rd(A_ST, 8'h00, "level gone");
    tend("level");
    wr(A_CT, 8'h0a);
    @(posedge clk_sys);
    blk <= 1'b1;
    repeat (5) @(posedge clk_sys);
    blk <= 1'b0;
    rd(A_ST, 8'h80, "status block start");
    tend("block start");
    wr(A_CT, 8'h50);
    rd(A_ST, 8'h40, "ratio mismatch");
    @(posedge clk_sys);
    ratio <= 2'b01;
    rd(A_ST, 8'h40, "ratio before match");
    rd(A_ST, 8'h00, "ratio match");
    tend("ratio");
    wr(A_CT, 8'h00);
    rate(16'h001e, 8'h00);
    rate(16'h0028, 8'h20);
    rate(16'h0003, 8'h20);
    tend("rate");
    @(posedge clk_sys);
    sample_valid <= 1'b1;
    left_acc <= 26'sh1000000;
    right_acc <= -26'sh1000000;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    @(posedge clk_sys);
    chk_reg("left clip", 32'h007fffff, {8'h00, left_s});
    chk_reg("right clip", 32'h00800000, {8'h00, right_s});
    rd(A_ST, 8'h18, "status overrange");
    tend("overrange");
    // Every unmasked event so far has also landed in the sticky interrupt bits.
    rd(A_IS, 8'hff, "irq_stat sticky");
    wr(A_IC, 8'hff);
    rd(A_IS, 8'h00, "irq_stat cleared");
    wr(A_IE, 8'h01);
    fire(4);
    @(posedge clk_sys);
    chk_pin("irq raised", 1'b1, irq);
    rd(A_IS, 8'h01, "irq_stat");
    wr(A_IC, 8'h01);
    @(posedge clk_sys);
    chk_pin("irq cleared", 1'b0, irq);
    wr(A_IE, 8'h00);
    fire(4);
    @(posedge clk_sys);
    chk_pin("irq disabled", 1'b0, irq);
    wr(A_MK, 8'h00);
    rd(A_ST, 8'h00, "mask off clears");
    tend("interrupt");
    // A second reset in mid-run, with a flag pending, must leave the interrupt, status, mask and interrupt enable at their reset values.
    wr(A_MK, 8'hff);
    wr(A_IE, 8'h01);
    fire(4);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk_pin("irq after reset", 1'b0, irq);
    rd(A_ST, `ASI_STATUS_RST, "status after reset");
    rd(A_MK, `ASI_MASK_RST, "mask after reset");
    rd(A_IE, `ASI_IRQ_RST, "irq_en after reset");
    tend("reset again");
    end_of_test();
  end
endmodule : asi_top_tb

/* rtl/asi_flag.sv */
// One clear-on-read event status bit with level-mode hold and mask gating.
// Assumes set, active and clear are synchronous to the system clock.
`timescale 1ns/1ps
module asi_flag (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_b_in,
  // Event side
  input  wire logic set_in,
  input  wire logic active_in,
  input  wire logic level_in,
  // Software side
  input  wire logic enable_in,
  input  wire logic clear_in,
  output logic      flag_out
);
  logic flag_q;
  logic flag_d;

  // A set in the clearing cycle wins, so no event is lost to a read.
  always_comb begin
    flag_d = flag_q;
    if (clear_in) begin
      flag_d = level_in & active_in;
    end
    if (set_in) begin
      flag_d = 1'b1;
    end
    flag_d = flag_d & enable_in;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_out = flag_q & enable_in;
endmodule : asi_flag

/* rtl/asi_sync.sv */
// Two-flop synchroniser for levels arriving from pins.
// Assumes the input is a slow level relative to the system clock.
`timescale 1ns/1ps
module asi_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         rst_b_in,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : asi_sync

/* rtl/asi_top.sv */
// Audio event status block: eight clear-on-read event flags, mask, control and interrupt.
// Assumes event inputs are on clk_sys_in except the block-start pin, which is synchronised.
// Notes on behaviour
// - A flag latches one after its event and stays until read or until its mask bit is cleared.
// - Reading the status register clears all flags except those whose event is present in the reading cycle.
// - In level mode a flag whose source is still true survives the read.
// - Flags disabled in the mask register always read zero.
// - After reset all eight flags read zero.
// - Bypassed converter with asynchronous master clock: each dropped sample sets transmitter slip.
// - Block-start as input with converter unused: each block-start pulse sets transmitter slip.
// - Slave output port with asynchronous frame clock: each slipped sample sets output slip.
// - Converter into slave port: wrong clock ratio sets output slip.
// - Mask register at index 09h holds one enable per flag.
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "asi_regs.svh"
module asi_top #(
  parameter int SW = 24,
  parameter int PW = 16
) (
  // Clock and reset
  input  wire logic                clk_sys_in,
  input  wire logic                rst_b_in,
  // Avalon-MM slave
  input  wire logic [7:0]          address_in,
  input  wire logic                read_in,
  input  wire logic                write_in,
  input  wire logic [31:0]         writedata_in,
  output logic      [31:0]         readdata_out,
  output logic                     waitrequest_out,
  // Interrupt
  output logic                     irq_out,
  // Slip and block-start sources
  input  wire logic                tx_sample_slip_in,
  input  wire logic                transmit_block_start_in,
  input  wire logic                out_sample_slip_in,
  input  wire logic [1:0]          out_clock_ratio_in,
  // Rate measurement
  input  wire logic                rate_valid_in,
  input  wire logic [PW-1:0]       in_period_in,
  input  wire logic [PW-1:0]       out_period_in,
  // Converter output samples
  input  wire logic                sample_valid_in,
  input  wire logic signed [SW+1:0] left_acc_in,
  input  wire logic signed [SW+1:0] right_acc_in,
  output logic      [SW-1:0]       left_sample_out,
  output logic      [SW-1:0]       right_sample_out,
  // Buffer and receiver sources
  input  wire logic                d_to_e_active_in,
  input  wire logic                e_to_f_active_in,
  input  wire logic                rx_error_in
);
  localparam logic signed [SW+1:0] POS_FS = (SW+2)'((64'sd1 <<< (SW-1)) - 1);
  localparam logic signed [SW+1:0] NEG_FS = (SW+2)'(-(64'sd1 <<< (SW-1)));

  logic                  rst_meta_q;
  logic                  rst_n;
  asi_pkg::asi_bus_state_t bus_q;
  asi_pkg::asi_byte_t    mask_q;
  asi_pkg::asi_byte_t    ctrl_q;
  asi_pkg::asi_byte_t    irq_stat_q;
  asi_pkg::asi_byte_t    irq_en_q;
  asi_pkg::asi_byte_t    status;
  asi_pkg::asi_byte_t    set_vec;
  asi_pkg::asi_byte_t    act_vec;
  logic [5:0]            idx;
  logic                  take;
  logic                  rd_clr;
  logic                  blk_sync;
  logic                  blk_prev_q;
  logic                  blk_rise;
  logic                  rate_over;
  logic                  over_l;
  logic                  over_r;
  logic                  ratio_bad;
  logic                  bypass;
  logic                  out_slave;

  // Reset is asserted at once and released through two flops.
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Bus: one wait state, the request is taken on the first cycle it is seen.
  assign idx             = address_in[7:2];
  assign take            = (read_in | write_in) && bus_q == asi_pkg::ASI_IDLE;
  assign waitrequest_out = (read_in | write_in) && bus_q != asi_pkg::ASI_ACK;
  // Clearing on the capture edge keeps an event after the capture from being lost.
  assign rd_clr          = take && read_in && idx == `ASI_IDX_STATUS;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= asi_pkg::ASI_IDLE;
    end else begin
      unique case (bus_q)
        asi_pkg::ASI_IDLE: begin
          if (read_in | write_in) begin
            bus_q <= asi_pkg::ASI_ACK;
          end
        end
        asi_pkg::ASI_ACK: begin
          bus_q <= asi_pkg::ASI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      readdata_out <= 32'h0000_0000;
    end else if (take && read_in) begin
      unique case (idx)
        `ASI_IDX_STATUS:   readdata_out <= {24'h00_0000, status};
        `ASI_IDX_MASK:     readdata_out <= {24'h00_0000, mask_q};
        `ASI_IDX_CTRL:     readdata_out <= {24'h00_0000, ctrl_q};
        `ASI_IDX_IRQ_STAT: readdata_out <= {24'h00_0000, irq_stat_q};
        `ASI_IDX_IRQ_EN:   readdata_out <= {24'h00_0000, irq_en_q};
        default:           readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= `ASI_MASK_RST;
    end else if (take && write_in && idx == `ASI_IDX_MASK) begin
      mask_q <= writedata_in[7:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `ASI_CTRL_RST;
    end else if (take && write_in && idx == `ASI_IDX_CTRL) begin
      ctrl_q <= writedata_in[7:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_q <= `ASI_IRQ_RST;
    end else if (take && write_in && idx == `ASI_IDX_IRQ_EN) begin
      irq_en_q <= writedata_in[7:0];
    end
  end

  // Sticky interrupt bits; a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= `ASI_IRQ_RST;
    end else if (take && write_in && idx == `ASI_IDX_IRQ_CLR) begin
      irq_stat_q <= (irq_stat_q & ~writedata_in[7:0]) | (set_vec & mask_q);
    end else begin
      irq_stat_q <= irq_stat_q | (set_vec & mask_q);
    end
  end

  assign irq_out = |(irq_stat_q & irq_en_q);

  // Block-start pin edge, seen only after synchronisation.
  asi_sync #(.W(1)) u_blk_sync (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_n),
    .async_in   (transmit_block_start_in),
    .sync_out   (blk_sync)
  );

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      blk_prev_q <= 1'b0;
    end else begin
      blk_prev_q <= blk_sync;
    end
  end

  assign blk_rise  = blk_sync & ~blk_prev_q;
  assign bypass    = ctrl_q[`ASI_C_BYPASS];
  assign out_slave = ctrl_q[`ASI_C_OUT_SLAVE];
  assign ratio_bad = out_clock_ratio_in != {ctrl_q[`ASI_C_RATIO_HI], ctrl_q[`ASI_C_RATIO_LO]};
  // A larger period means a lower rate, so each ratio is tested as period against three periods.
  assign rate_over = rate_valid_in &&
                     (({2'b00, out_period_in} > (PW+2)'(`ASI_RATE_LIMIT) * {2'b00, in_period_in}) ||
                      ({2'b00, in_period_in} > (PW+2)'(`ASI_RATE_LIMIT) * {2'b00, out_period_in}));
  assign over_l    = sample_valid_in && (left_acc_in > POS_FS || left_acc_in < NEG_FS);
  assign over_r    = sample_valid_in && (right_acc_in > POS_FS || right_acc_in < NEG_FS);

  always_comb begin
    set_vec = 8'h00;
    set_vec[`ASI_B_TX_SLIP]   = (bypass && ctrl_q[`ASI_C_OUTPUT_MASTER_CLOCK_ASYNC] && tx_sample_slip_in)
                              || (bypass && ctrl_q[`ASI_C_BLK_IN] && blk_rise);
    set_vec[`ASI_B_OUT_SLIP]  = (out_slave && ctrl_q[`ASI_C_FRM_ASYNC] && out_sample_slip_in)
                              || (!bypass && out_slave && ratio_bad);
    set_vec[`ASI_B_RATE]      = rate_over;
    set_vec[`ASI_B_OVR_LEFT]  = over_l;
    set_vec[`ASI_B_OVR_RIGHT] = over_r;
    set_vec[`ASI_B_D_TO_E]    = d_to_e_active_in;
    set_vec[`ASI_B_E_TO_F]    = e_to_f_active_in;
    set_vec[`ASI_B_RX_ERR]    = rx_error_in;
  end

  // Pulse sources are only active in their own cycle; level sources hold a flag over a read.
  assign act_vec = set_vec;

  for (genvar i = 0; i < 8; i++) begin : g_flag
    asi_flag u_flag (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_n),
      .set_in     (set_vec[i]),
      .active_in  (act_vec[i]),
      .level_in   (ctrl_q[`ASI_C_LEVEL]),
      .enable_in  (mask_q[i]),
      .clear_in   (rd_clr),
      .flag_out   (status[i])
    );
  end

  // Clipped converter output; the flag and the clip come from the same compare.
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      left_sample_out  <= '0;
      right_sample_out <= '0;
    end else if (sample_valid_in) begin
      left_sample_out  <= over_l ? (left_acc_in > POS_FS ? POS_FS[SW-1:0] : NEG_FS[SW-1:0])
                                 : left_acc_in[SW-1:0];
      right_sample_out <= over_r ? (right_acc_in > POS_FS ? POS_FS[SW-1:0] : NEG_FS[SW-1:0])
                                 : right_acc_in[SW-1:0];
    end
  end

  // Checks.
  sequence rd_status_s;
    rd_clr && !(|set_vec) && !ctrl_q[`ASI_C_LEVEL];
  endsequence

  sequence mask_wr_s;
    take && write_in && idx == `ASI_IDX_MASK;
  endsequence

  status_after_reset_a: assert property (@(posedge clk_sys_in) $rose(rst_n) |-> status == 8'h00)
    else $error("status not zero after reset");
  status_masked_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n) (status & ~mask_q) == 8'h00)
    else $error("masked status bit reads one");
  flag_latch_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      rx_error_in && mask_q[`ASI_B_RX_ERR] ##1 !rd_clr && $stable(mask_q) |-> status[`ASI_B_RX_ERR])
    else $error("event flag did not stay latched");
  read_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n) rd_status_s |=> status == 8'h00)
    else $error("status read did not clear flags");
  level_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      rd_clr && ctrl_q[`ASI_C_LEVEL] && d_to_e_active_in && mask_q[`ASI_B_D_TO_E] |=> status[`ASI_B_D_TO_E])
    else $error("level source cleared by read");
  tx_slip_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      bypass && ctrl_q[`ASI_C_OUTPUT_MASTER_CLOCK_ASYNC] && tx_sample_slip_in && mask_q[`ASI_B_TX_SLIP]
      |=> status[`ASI_B_TX_SLIP])
    else $error("sample slip did not set transmitter flag");
  blk_slip_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      bypass && ctrl_q[`ASI_C_BLK_IN] && $rose(blk_sync) && mask_q[`ASI_B_TX_SLIP] |=> status[`ASI_B_TX_SLIP])
    else $error("block start did not set transmitter flag");
  out_slip_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      out_slave && ctrl_q[`ASI_C_FRM_ASYNC] && out_sample_slip_in && mask_q[`ASI_B_OUT_SLIP]
      |=> status[`ASI_B_OUT_SLIP])
    else $error("output slip not flagged");
  ratio_slip_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      !bypass && out_slave && ratio_bad && mask_q[`ASI_B_OUT_SLIP] |=> status[`ASI_B_OUT_SLIP])
    else $error("clock ratio mismatch not flagged");
  rate_flag_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      rate_valid_in && {2'b00, out_period_in} > `ASI_RATE_LIMIT * {2'b00, in_period_in} && mask_q[`ASI_B_RATE]
      |=> status[`ASI_B_RATE])
    else $error("rate ratio above three not flagged");
  mask_write_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      mask_wr_s |=> mask_q == $past(writedata_in[7:0]) ##1 waitrequest_out == 1'b0 || !write_in)
    else $error("mask register did not take write");
  clip_left_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      sample_valid_in && left_acc_in > POS_FS && mask_q[`ASI_B_OVR_LEFT]
      |=> left_sample_out == POS_FS[SW-1:0] && status[`ASI_B_OVR_LEFT])
    else $error("left overrange not clipped and flagged");
  transfer_flag_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      e_to_f_active_in && mask_q[`ASI_B_E_TO_F] |=> status[`ASI_B_E_TO_F])
    else $error("transfer flag not set");

  // Status is captured on the edge that clears it, so the read must return the value from before the clear.
  read_data_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      take && read_in && idx == `ASI_IDX_STATUS |=> readdata_out[7:0] == $past(status))
    else $error("status read returned wrong value");
  clip_right_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      sample_valid_in && right_acc_in < NEG_FS && mask_q[`ASI_B_OVR_RIGHT]
      |=> right_sample_out == NEG_FS[SW-1:0] && status[`ASI_B_OVR_RIGHT])
    else $error("right overrange not clipped and flagged");
  rate_rev_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      rate_valid_in && {2'b00, in_period_in} > `ASI_RATE_LIMIT * {2'b00, out_period_in} && mask_q[`ASI_B_RATE]
      |=> status[`ASI_B_RATE])
    else $error("reverse rate ratio above three not flagged");
  irq_set_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      rx_error_in && mask_q[`ASI_B_RX_ERR] && irq_en_q[`ASI_B_RX_ERR] && !(take && write_in) |=> irq_out)
    else $error("enabled event did not raise interrupt");
endmodule : asi_top
